/* File: rtl/i2ra_consts.vh */
// Constants for the two-wire register access target.
// Assumes inclusion by the target module only; definitions only.
`ifndef I2RA_CONSTS_VH
`define I2RA_CONSTS_VH

// ----------------------------------------------------------------------
// Target address and opcodes
// ----------------------------------------------------------------------
`define I2RA_ADDR_HI     4'hd   // Upper address bits, 68h with select 000
`define I2RA_OP_WRITE    3'b011 // Register write opcode
`define I2RA_OP_READ     3'b100 // Register read opcode

// ----------------------------------------------------------------------
// Byte positions inside a packet
// ----------------------------------------------------------------------
`define I2RA_IDX_ADDR    4'h0   // Address byte
`define I2RA_IDX_CMD0    4'h1   // Command byte 0
`define I2RA_IDX_CMD3    4'h4   // Command byte 3
`define I2RA_IDX_DATA3   4'h8   // Last write data byte
`define I2RA_IDX_MAX     4'h9   // Saturation point of the byte index

// ----------------------------------------------------------------------
// Bit count and reset word
// ----------------------------------------------------------------------
`define I2RA_BITS_BYTE   4'h8   // Bits in one byte
`define I2RA_RST_WORD    32'h0000_0000

`endif

/* File: rtl/i2ra_target.v */
// Two-wire bus target giving a master access to 32-bit switch registers.
// Assumes scl and sda arrive asynchronously and are oversampled by clk;
// the register store answers a read request with reg_rd_ack on clk.
//
// Overview of operation
// - Read uses command packet then read packet
// - Address bit 0 set means read
// - Read command fetches register into internal buffer
// - Read data goes out high byte first
// - Past four bytes, resend from high byte
// - Repeated start joins command and data packets
// - Command byte 0 bits 2:0 opcode, 100b read
// - Port is byte1 bits 3:0 plus byte2 bit7
// - Byte2 bits 5:2 are lane enables
// - Address from byte2 bits 1:0, byte3
// - Answer 68h when select inputs are 000
// - Address byte holds address in bits 7:1
// - Opcode 011b requests a register write
// - Write data high byte first, enabled lanes
`timescale 1ns/1ps
`include "i2ra_consts.vh"

module i2ra_target (
  input  wire        clk,          // System clock, 40 MHz
  input  wire        nrst,         // Synchronous reset, active low
  input  wire        scl_i,        // Bus clock pin level
  input  wire        sda_i,        // Bus data pin level
  output reg         sda_o,        // Bus data drive value, always low
  output reg         sda_oe,       // High while pulling sda low
  input  wire [2:0]  addr_sel,     // Address select inputs
  output reg         reg_rd_req,   // One-cycle register read request
  output reg         reg_wr_req,   // One-cycle register write request
  output reg  [4:0]  reg_port,     // Selected port
  output reg  [11:0] reg_addr,     // Register byte address
  output reg  [3:0]  reg_be,       // Lane enables, bit 3 = bits 31:24
  output reg  [31:0] reg_wdata,    // Write data
  input  wire [31:0] reg_rdata,    // Read data from register store
  input  wire        reg_rd_ack    // Read data valid, one cycle
);

  // --------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------
  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_RX   = 5'b00010;
  localparam [4:0] ST_ACK  = 5'b00100;
  localparam [4:0] ST_TX   = 5'b01000;
  localparam [4:0] ST_TACK = 5'b10000;

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  reg  [2:0]  scl_sync_q;   // Three-stage pin samplers
  reg  [2:0]  sda_sync_q;
  reg  [2:0]  sel_s1_q;
  reg  [2:0]  sel_s2_q;
  reg  [2:0]  sel_s3_q;
  reg         scl_f_q;      // Filtered levels
  reg         sda_f_q;
  reg  [2:0]  sel_f_q;
  reg  [4:0]  state_q;
  reg  [3:0]  bit_cnt_q;
  reg  [7:0]  shift_q;
  reg  [3:0]  byte_idx_q;
  reg         is_read_q;
  reg  [2:0]  opcode_q;
  reg  [1:0]  tx_sel_q;
  reg  [31:0] buf_q;
  wire        scl_n;
  wire        sda_n;
  wire        scl_rise;
  wire        scl_fall;
  wire        bus_start;
  wire        bus_stop;
  wire [7:0]  tx_byte;

  // Buffer byte picked by lane index, 0 = bits 31:24
  function [7:0] buf_byte;
    input [31:0] word;
    input [1:0]  sel;
    begin
      case (sel)
        2'd0:    buf_byte = word[31:24];
        2'd1:    buf_byte = word[23:16];
        2'd2:    buf_byte = word[15:8];
        default: buf_byte = word[7:0];
      endcase
    end
  endfunction

  // --------------------------------------------------------------------
  // Pin sampling
  // --------------------------------------------------------------------
  // A level counts once the second and third stages agree, which also
  // rejects single-sample glitches on the slow bus lines.
  always @(posedge clk) begin
    if (!nrst) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
      sel_s1_q   <= 3'h0;
      sel_s2_q   <= 3'h0;
      sel_s3_q   <= 3'h0;
      scl_f_q    <= 1'b1;
      sda_f_q    <= 1'b1;
      sel_f_q    <= 3'h0;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], scl_i};
      sda_sync_q <= {sda_sync_q[1:0], sda_i};
      sel_s1_q   <= addr_sel;
      sel_s2_q   <= sel_s1_q;
      sel_s3_q   <= sel_s2_q;
      scl_f_q    <= scl_n;
      sda_f_q    <= sda_n;
      if (sel_s2_q == sel_s3_q)
        sel_f_q <= sel_s3_q;
    end
  end

  assign scl_n = (scl_sync_q[1] == scl_sync_q[2]) ? scl_sync_q[2] : scl_f_q;
  assign sda_n = (sda_sync_q[1] == sda_sync_q[2]) ? sda_sync_q[2] : sda_f_q;

  // Bus events; start and stop only while scl is high
  assign scl_rise  = !scl_f_q && scl_n;
  assign scl_fall  = scl_f_q && !scl_n;
  assign bus_start = scl_f_q && scl_n && sda_f_q && !sda_n;
  assign bus_stop  = scl_f_q && scl_n && !sda_f_q && sda_n;
  assign tx_byte   = buf_byte(buf_q, tx_sel_q);

  // --------------------------------------------------------------------
  // Read buffer
  // --------------------------------------------------------------------
  // Held until the next read fetch, so a later packet can re-read it
  always @(posedge clk) begin
    if (!nrst)
      buf_q <= `I2RA_RST_WORD;
    else if (reg_rd_ack)
      buf_q <= reg_rdata;
  end

  // --------------------------------------------------------------------
  // Protocol engine
  // --------------------------------------------------------------------
  always @(posedge clk) begin
    if (!nrst) begin
      state_q    <= ST_IDLE;
      bit_cnt_q  <= 4'h0;
      shift_q    <= 8'h00;
      byte_idx_q <= 4'h0;
      is_read_q  <= 1'b0;
      opcode_q   <= 3'h0;
      tx_sel_q   <= 2'h0;
      sda_oe     <= 1'b0;
      sda_o      <= 1'b0; // Open drain: only ever pulls low
      reg_rd_req <= 1'b0;
      reg_wr_req <= 1'b0;
      reg_port   <= 5'h00;
      reg_addr   <= 12'h000;
      reg_be     <= 4'h0;
      reg_wdata  <= 32'h0000_0000;
    end else begin
      sda_o      <= 1'b0;
      reg_rd_req <= 1'b0;
      reg_wr_req <= 1'b0;
      if (bus_start) begin
        // A repeated start restarts the address phase, keeping the buffer
        state_q    <= ST_RX;
        bit_cnt_q  <= 4'h0;
        byte_idx_q <= `I2RA_IDX_ADDR;
        sda_oe     <= 1'b0;
      end else if (bus_stop) begin
        state_q <= ST_IDLE;
        sda_oe  <= 1'b0;
      end else begin
        case (state_q)
          ST_IDLE: begin
            sda_oe <= 1'b0;
          end
          ST_RX: begin
            if (scl_rise) begin
              shift_q   <= {shift_q[6:0], sda_f_q};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (scl_fall && bit_cnt_q == `I2RA_BITS_BYTE) begin
              bit_cnt_q <= 4'h0;
              state_q   <= ST_ACK;
              sda_oe    <= 1'b1;
              if (byte_idx_q == `I2RA_IDX_ADDR) begin
                if (shift_q[7:1] != {`I2RA_ADDR_HI, sel_f_q}) begin
                  state_q <= ST_IDLE;
                  sda_oe  <= 1'b0;
                end
                is_read_q <= shift_q[0];
              end
              case (byte_idx_q)
                `I2RA_IDX_CMD0: opcode_q <= shift_q[2:0];
                4'h2: reg_port[4:1] <= shift_q[3:0];
                4'h3: begin
                  reg_port[0]     <= shift_q[7];
                  reg_be          <= shift_q[5:2];
                  reg_addr[11:10] <= shift_q[1:0];
                end
                `I2RA_IDX_CMD3: begin
                  reg_addr[9:0] <= {shift_q, 2'b00};
                  if (opcode_q == `I2RA_OP_READ)
                    reg_rd_req <= 1'b1;
                end
                4'h5: reg_wdata[31:24] <= shift_q;
                4'h6: reg_wdata[23:16] <= shift_q;
                4'h7: reg_wdata[15:8]  <= shift_q;
                `I2RA_IDX_DATA3: begin
                  reg_wdata[7:0] <= shift_q;
                  if (opcode_q == `I2RA_OP_WRITE)
                    reg_wr_req <= 1'b1;
                end
                default: ;
              endcase
            end
          end
          ST_ACK: begin
            // Release after the ninth clock; a read starts sending at once
            if (scl_fall) begin
              if (is_read_q) begin
                tx_sel_q  <= 2'h0;
                sda_oe    <= ~buf_q[31];
                bit_cnt_q <= 4'h1;
                state_q   <= ST_TX;
              end else begin
                sda_oe  <= 1'b0;
                state_q <= ST_RX;
                if (byte_idx_q != `I2RA_IDX_MAX)
                  byte_idx_q <= byte_idx_q + 4'h1;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt_q == `I2RA_BITS_BYTE) begin
                sda_oe  <= 1'b0; // Master drives the acknowledge
                state_q <= ST_TACK;
              end else begin
                sda_oe    <= ~tx_byte[3'd7 - bit_cnt_q[2:0]];
                bit_cnt_q <= bit_cnt_q + 4'h1;
              end
            end
          end
          ST_TACK: begin
            if (scl_rise) begin
              if (sda_f_q) begin
                state_q <= ST_IDLE;
              end else begin
                tx_sel_q  <= tx_sel_q + 2'h1;
                bit_cnt_q <= 4'h0;
                state_q   <= ST_TX;
              end
            end
          end
          default: begin
            state_q <= ST_IDLE;
            sda_oe  <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule // i2ra_target

/* File: sim/i2ra_master.sv */
// Two-wire bus master model: scl plus an open-drain data pull-down.
// Assumes the bench resolves sda from all pull-downs and a pull-up.
`timescale 1ns/1ps
module i2ra_master (
  output logic scl,    // Bus clock, high between frames
  output logic sda_dn, // High while pulling sda low
  input  wire  sda     // Resolved bus data
);
  logic r;
  initial begin
    scl = 1'b1;
    sda_dn = 1'b0;
  end
  // Long low phase leaves room for the target's filter delay
  // Pin moves land on clk edges as non-blocking updates, so the
  // target's samplers always see the old level there, never a race
  task bit_x(input logic b, output logic q);
    #50 sda_dn <= !b;
    #100 scl <= 1'b1;
    #40 q = sda;
    #10 scl <= 1'b0;
  endtask
  // Start from idle, or repeated start with scl low
  task start;
    #50 sda_dn <= 1'b0;
    #100 scl <= 1'b1;
    #50 sda_dn <= 1'b1;
    #50 scl <= 1'b0;
  endtask
  // Clock stands high after the stop
  task stop;
    #50 sda_dn <= 1'b1;
    #100 scl <= 1'b1;
    #50 sda_dn <= 1'b0;
    #100;
  endtask
  task wr_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, ack);
    ack = !ack;
  endtask
  task rd_byte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(last, r);
  endtask
endmodule // i2ra_master

/* File: sim/i2ra_monitor.sv */
// Checker of bus drive timing and register request pulses.
// Assumes binding onto i2ra_target; watches its ports only.
`timescale 1ns/1ps
module i2ra_monitor (
  input wire        clk,        // System clock
  input wire        nrst,       // Reset, active low
  input wire        scl_i,      // Bus clock level
  input wire        sda_oe,     // Data pull-down enable
  input wire        reg_rd_req, // Read request pulse
  input wire        reg_wr_req, // Write request pulse
  input wire [11:0] reg_addr    // Register byte address
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_rd_pulse:
    assert property (reg_rd_req |=> !reg_rd_req) else $error("rd long");
  chk_wr_pulse:
    assert property (reg_wr_req |=> !reg_wr_req) else $error("wr long");
  chk_req_excl:
    assert property (!(reg_rd_req && reg_wr_req)) else $error("rd and wr");
  chk_addr_align:
    assert property (reg_addr[1:0] == 2'b00) else $error("addr unaligned");
  chk_req_scl_low:
    assert property ((reg_rd_req || reg_wr_req) |-> !scl_i)
      else $error("req in high");
  // Drive edges only while scl is low, so data never moves in high
  chk_oe_rise:
    assert property ($rose(sda_oe) |-> !scl_i) else $error("oe rise");
  chk_oe_fall:
    assert property ($fell(sda_oe) |-> !scl_i) else $error("oe fall");
  chk_oe_width:
    assert property ($rose(sda_oe) |=> sda_oe [*6]) else $error("oe short");
  cover property (reg_rd_req);
  cover property (reg_wr_req);
  cover property ($rose(sda_oe));
endmodule // i2ra_monitor

bind i2ra_target i2ra_monitor u_i2ra_monitor (.clk, .nrst, .scl_i,
  .sda_oe, .reg_rd_req, .reg_wr_req, .reg_addr);

/* File: sim/i2ra_target_test.sv */
// Self-checking bench: master model on the bus, store model in here.
// Assumes sda has a pull-up and every party only pulls it low.
`timescale 1ns/1ps
module i2ra_target_test;
  logic        clk, scl, dn, ack;
  logic        nrst = 1'b0, reg_rd_ack = 1'b0;
  logic [2:0]  sel, addr_sel = 3'h0;
  logic [4:0]  port;
  logic [3:0]  be;
  logic [9:0]  ra;
  logic [7:0]  b;
  logic [21:0] cap;
  logic [31:0] w, v, capw, seed = 32'h177b, ncap = 0, cyc = 0;
  logic [31:0] reg_rdata = 0, rd_word = 0, fail_count = 0, tests_run = 0;
  wire         sda_oe, sda_o, reg_rd_req, reg_wr_req;
  wire [4:0]   reg_port;
  wire [11:0]  reg_addr;
  wire [3:0]   reg_be;
  wire [31:0]  reg_wdata;
  wire         sda = !dn && (!sda_oe || sda_o); // Wired AND, pull-up
  i2ra_target u_i2ra_target (.clk, .nrst, .scl_i(scl), .sda_i(sda),
    .sda_o, .sda_oe, .addr_sel, .reg_rd_req, .reg_wr_req, .reg_port,
    .reg_addr, .reg_be, .reg_wdata, .reg_rdata, .reg_rd_ack);
  i2ra_master u_i2ra_master (.scl, .sda_dn(dn), .sda);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Store: inverted data unless acking, so only the acked word fits
  always @(posedge clk) begin
    reg_rd_ack <= reg_rd_req;
    reg_rdata <= reg_rd_req ? rd_word : ~rd_word;
    cyc <= cyc + 1;
    if (reg_rd_req || reg_wr_req) begin
      cap <= {reg_wr_req, reg_port, reg_addr, reg_be};
      capw <= reg_wdata;
      ncap <= ncap + 1;
    end
    if (cyc == 32'd40000) begin
      fail_count++;
      give_verdict;
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function logic [6:0] tgt(input logic [2:0] s);
    return {4'hd, s};
  endfunction
  function logic [7:0] exp_byte(input logic [31:0] x, input int k);
    return x[31 - 8 * (k % 4) -: 8];
  endfunction
  task chk_val(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // One compare per kind of result, all counted in chk_val
  task chk_ack(input logic g, input logic e);
    chk_val({31'h0, g}, {31'h0, e});
  endtask
  task chk_byte(input logic [7:0] g, input logic [7:0] e);
    chk_val({24'h0, g}, {24'h0, e});
  endtask
  task chk_req(input logic [21:0] g, input logic [21:0] e);
    chk_val({10'h0, g}, {10'h0, e});
  endtask
  task chk_count(input logic [31:0] g, input logic [31:0] e);
    chk_val(g, e);
  endtask
  task send(input logic [7:0] d, input logic e);
    u_i2ra_master.wr_byte(d, ack);
    chk_ack(ack, e);
  endtask
  task pkt(input logic [2:0] o);
    u_i2ra_master.start;
    send({tgt(sel), 1'b0}, 1'b1);
    send({5'h0, o}, 1'b1);
    send({4'h0, port[4:1]}, 1'b1);
    send({port[0], 1'b0, be, ra[9:8]}, 1'b1);
    send(ra[7:0], 1'b1);
  endtask
  task give_verdict;
    $display("compares %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // First pass is the plain example, the rest random corners
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    for (int it = 0; it < 6; it++) begin
      w = rnd();
      v = rnd();
      {sel, port, be, ra} = {w[2:0], 5'(v % 6), v[7:4], w[13:4]};
      if (it == 0)
        {sel, port, be, ra, w} = {3'h0, 5'h0, 4'hf, 10'h03e, 32'h12345678};
      @(posedge clk);
      addr_sel <= sel;
      rd_word <= v;
      repeat (8) @(posedge clk);
      pkt(3'b011);
      for (int k = 0; k < 4; k++) send(exp_byte(w, k), 1'b1);
      u_i2ra_master.stop;
      chk_req(cap, {1'b1, port, ra, 2'b00, be});
      chk_val(capw, w);
      pkt(3'b100);
      if (it % 2) u_i2ra_master.stop;
      u_i2ra_master.start;
      send({tgt(sel), 1'b1}, 1'b1);
      for (int k = 0; k < 6; k++) begin
        u_i2ra_master.rd_byte(k == 5, b);
        chk_byte(b, exp_byte(v, k));
      end
      u_i2ra_master.stop;
      chk_req(cap, {1'b0, port, ra, 2'b00, be});
      u_i2ra_master.start;
      send({tgt(sel ^ 3'h1), 1'b0}, 1'b0);
      u_i2ra_master.stop;
      pkt(3'b000);
      send(w[7:0], 1'b1);
      u_i2ra_master.stop;
      chk_count(ncap, 32'(2 * it + 2));
      $display("test %0d done", it);
    end
    give_verdict;
  end
endmodule // i2ra_target_test
